// >>> sim/mie_core_model.sv
// Core model: acknowledges a gated request with a one-cycle pulse
`timescale 1ns/1ps
module mie_core_model (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_auto_ack,
  input wire logic i_irq_req,
  input wire logic [7:0] i_pending,
  output logic o_ack,
  output logic [7:0] o_ack_src
);
  // A real core takes every source it sees, so the mask is the full pending image
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_ack <= 1'b0;
      o_ack_src <= 8'h00;
    end else begin
      o_ack <= i_auto_ack & i_irq_req & ~o_ack;
      o_ack_src <= i_pending;
    end
  end
endmodule

// >>> sim/test_master_interrupt_enable.sv
// Testbench for the master interrupt enable block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t mismatch", $time); end end
module test_master_interrupt_enable;
  import mie_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] cmd = 3'h0;
  logic auto_ack = 1'b0;
  logic clk_en = 1'b1;
  logic ack, gate, req, seen;
  logic [7:0] ack_src, pend, ctrl;
  logic [7:0] irq = 8'h00;
  mie_ctrl_wr_type wr = '0;
  mie_core_evt_type evt;
  int n_errors = 0;
  int n_compared = 0;
  assign evt = {cmd, ack};
  mie_master_int_enable dut (.i_sys_clk(clk), .i_srst(srst), .i_clk_en(clk_en), .i_core_evt(evt),
    .i_ctrl_wr(wr), .i_irq_src(irq), .i_ack_src(ack_src), .o_global_int_gate(gate),
    .o_irq_req(req), .o_pending(pend), .o_ctrl_value(ctrl));
  mie_core_model core (.i_sys_clk(clk), .i_srst(srst), .i_auto_ack(auto_ack), .i_irq_req(req),
    .i_pending(pend), .o_ack(ack), .o_ack_src(ack_src));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One pulse of instruction and software write, then look after its edge
  task step(input logic [2:0] c, input logic w, input logic [7:0] d);
    @(posedge clk);
    cmd <= c;
    wr <= '{w, d};
    @(posedge clk);
    cmd <= 3'h0;
    wr <= '0;
    #1;
  endtask
  task t_instr;
    step(3'h4, 1'b0, 8'h00);
    `CHK(gate, 1'b1)
    `CHK(ctrl, 8'h80)
    step(3'h2, 1'b0, 8'h00);
    `CHK(gate, 1'b0)
    step(3'h1, 1'b0, 8'h00);
    `CHK(gate, 1'b1)
    step(3'h6, 1'b0, 8'h00);
    `CHK(gate, 1'b0)
  endtask
  task t_soft;
    step(3'h0, 1'b1, 8'h80);
    `CHK(ctrl, 8'h80)
    `CHK(gate, 1'b1)
    step(3'h0, 1'b1, 8'h7F);
    `CHK(ctrl, 8'h00)
    `CHK(gate, 1'b0)
  endtask
  // Low clock enable freezes the gate; a mid-run reset closes it again
  task t_freeze;
    step(3'h4, 1'b0, 8'h00);
    `CHK(gate, 1'b1)
    @(posedge clk);
    clk_en <= 1'b0;
    step(3'h2, 1'b0, 8'h00);
    `CHK(gate, 1'b1)
    @(posedge clk);
    clk_en <= 1'b1;
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(gate, 1'b0)
    `CHK(ctrl, 8'h00)
  endtask
  // Requests wait behind a closed gate, then the core takes them
  task t_pend;
    int i;
    @(posedge clk);
    irq <= 8'h05;
    @(posedge clk);
    irq <= 8'h00;
    repeat (3) @(posedge clk);
    #1;
    `CHK(req, 1'b0)
    `CHK(pend, 8'h05)
    auto_ack <= 1'b1;
    step(3'h4, 1'b0, 8'h00);
    seen = (req === 1'b1);
    for (i = 0; i < 20 && !(gate === 1'b0 && pend === 8'h00); i++) begin
      @(posedge clk);
      #1;
      if (req === 1'b1) seen = 1'b1;
    end
    if (i == 20) begin
      n_errors++;
      $display("BAD %0t pending never cleared", $time);
    end else begin
      `CHK(seen, 1'b1)
      `CHK(req, 1'b0)
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(gate, 1'b0)
    `CHK(ctrl, 8'h00)
    t_instr();
    t_soft();
    t_freeze();
    t_pend();
    give_verdict();
  end
endmodule

// >>> verilog/mie_master_int_enable.sv
// Master interrupt enable: global gate flag and gated request toward the core
//
// Functional notes
// - One master flag gates every request
// - Enable-interrupts instruction sets the flag
// - Return-from-service instruction sets the flag
// - Software writing one sets the flag
// - Disable-interrupts instruction clears the flag
// - Core acknowledge clears the flag
// - Software writing zero clears the flag
// - Reset clears the flag
`timescale 1ns/1ps
module mie_master_int_enable
  import mie_pkg::*;
#(
  parameter int N = NUM_SOURCES
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_clk_en,
  input wire mie_core_evt_type i_core_evt,
  input wire mie_ctrl_wr_type i_ctrl_wr,
  input wire logic [N-1:0] i_irq_src,
  input wire logic [N-1:0] i_ack_src,
  output logic o_global_int_gate,
  output logic o_irq_req,
  output logic [N-1:0] o_pending,
  output logic [CTRL_WIDTH-1:0] o_ctrl_value
);

  logic next_gate;
  logic [N-1:0] pending;

  ////////////////////////////////////////////////////////////////////////////
  // Gate flag
  // Core events outrank a software write in the same cycle; among them
  // the clearing ones win so an acknowledge can never leave the gate open.

  function automatic logic gate_from_write(input logic [CTRL_WIDTH-1:0] data);
    return data[GATE_BIT];
  endfunction

  always_comb begin
    next_gate = o_global_int_gate;
    if (i_core_evt.ack) begin
      next_gate = 1'b0;
    end else if (i_core_evt.disable_interrupts_instruction) begin
      next_gate = 1'b0;
    end else if (i_core_evt.enable_interrupts_instruction) begin
      next_gate = 1'b1;
    end else if (i_core_evt.return_from_service_instruction) begin
      next_gate = 1'b1;
    end else if (i_ctrl_wr.wr) begin
      next_gate = gate_from_write(i_ctrl_wr.data);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_global_int_gate <= GATE_RESET;
    end else if (i_clk_en) begin
      o_global_int_gate <= next_gate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending requests and gated output

  mie_pend_latch #(
    .N(N)
  ) u_pend (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_clk_en(i_clk_en),
    .i_set(i_irq_src),
    .i_clr_en(i_core_evt.ack),
    .i_clr(i_ack_src),
    .o_pending(pending)
  );

  // Request lags the pending latch by one cycle; costs a cycle of latency
  // but keeps the output straight from a flip-flop.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_irq_req <= 1'b0;
      o_pending <= '0;
    end else if (i_clk_en) begin
      o_irq_req <= next_gate & (|pending);
      o_pending <= pending;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_ctrl_value <= CTRL_RESET;
    end else if (i_clk_en) begin
      o_ctrl_value <= CTRL_RESET | (CTRL_WIDTH'(next_gate) << GATE_BIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  logic no_core;
  assign no_core = !i_core_evt.ack && !i_core_evt.disable_interrupts_instruction &&
                   !i_core_evt.enable_interrupts_instruction && !i_core_evt.return_from_service_instruction;

  AST_GATE_BLOCKS: assert property ((i_clk_en && !next_gate) |=> !o_irq_req)
    else $error("request passed while gate closed");

  AST_EI_SETS: assert property ((i_clk_en && i_core_evt.enable_interrupts_instruction &&
    !i_core_evt.ack && !i_core_evt.disable_interrupts_instruction) |=> o_global_int_gate)
    else $error("enable instruction did not open gate");

  AST_RET_SETS: assert property ((i_clk_en && i_core_evt.return_from_service_instruction &&
    !i_core_evt.ack && !i_core_evt.disable_interrupts_instruction) |=> o_global_int_gate)
    else $error("return instruction did not open gate");

  AST_WR1_SETS: assert property ((i_clk_en && no_core && i_ctrl_wr.wr && i_ctrl_wr.data[GATE_BIT])
    |=> (o_global_int_gate && o_ctrl_value[GATE_BIT]))
    else $error("write of one did not open gate");

  AST_DI_CLEARS: assert property ((i_clk_en && i_core_evt.disable_interrupts_instruction)
    |=> !o_global_int_gate)
    else $error("disable instruction did not close gate");

  AST_ACK_CLEARS: assert property ((i_clk_en && i_core_evt.ack) |=> (!o_global_int_gate && !o_irq_req))
    else $error("acknowledge did not close gate");

  AST_WR0_CLEARS: assert property ((i_clk_en && no_core && i_ctrl_wr.wr && !i_ctrl_wr.data[GATE_BIT])
    |=> !o_global_int_gate)
    else $error("write of zero did not close gate");

  AST_RESET_CLEARS: assert property (disable iff (1'b0) i_srst |=> (!o_global_int_gate && !o_irq_req))
    else $error("reset left gate or request set");

  sequence seq_req_while_closed;
    i_clk_en && !o_global_int_gate && (i_irq_src != '0) && !i_core_evt.ack;
  endsequence

  sequence seq_gate_opens;
    i_clk_en && next_gate && !i_core_evt.ack;
  endsequence

  AST_PEND_KEPT: assert property (seq_req_while_closed ##1 seq_gate_opens |=> o_irq_req)
    else $error("request lost while gate closed");

  ////////////////////////////////////////////////////////////////////////////
  // Clock-enable freeze and consistency checks
  // A low enable must hold every register; a stalled core would otherwise
  // lose an instruction event or see a request it never asked for.

  AST_FREEZE_GATE: assert property (
    !i_clk_en |=> $stable(o_global_int_gate))
    else $error("gate moved while clock enable low");

  AST_FREEZE_REQ: assert property (
    !i_clk_en |=> $stable(o_irq_req))
    else $error("request moved while clock enable low");

  AST_FREEZE_PEND: assert property (
    !i_clk_en |=> $stable(o_pending))
    else $error("pending image moved while clock enable low");

  AST_FREEZE_CTRL: assert property (
    !i_clk_en |=> $stable(o_ctrl_value))
    else $error("control image moved while clock enable low");

  // The control image shows the flag at its bit and nothing else
  AST_CTRL_MIRROR: assert property (
    o_ctrl_value[GATE_BIT] == o_global_int_gate)
    else $error("control image disagrees with gate");

  // No request can reach the core unless the flag is open
  AST_REQ_NEEDS_GATE: assert property (
    o_irq_req |-> o_global_int_gate)
    else $error("request raised with gate closed");

  AST_REQ_NEEDS_PEND: assert property (
    (i_clk_en && next_gate && (pending != '0)) |=> o_irq_req)
    else $error("open gate did not pass pending request");

  AST_PEND_MIRROR: assert property (
    i_clk_en |=> (o_pending == $past(pending)))
    else $error("pending image does not follow latch");

  // Without an acknowledge no latched request may disappear
  AST_PEND_HELD: assert property (
    (i_clk_en && !i_core_evt.ack) |=> ((pending & $past(pending)) == $past(pending)))
    else $error("pending request dropped without acknowledge");

  AST_ACK_DROPS: assert property (
    (i_clk_en && i_core_evt.ack) |=> ((pending & $past(i_ack_src) & ~$past(i_irq_src)) == '0))
    else $error("acknowledged source still pending");

  // Priority: a clearing core event beats any same-cycle set
  AST_ACK_BEATS_WR: assert property (
    (i_clk_en && i_core_evt.ack && i_ctrl_wr.wr && i_ctrl_wr.data[GATE_BIT]) |=> !o_global_int_gate)
    else $error("write reopened gate during acknowledge");

  AST_DI_BEATS_EI: assert property (
    (i_clk_en && i_core_evt.disable_interrupts_instruction && i_core_evt.enable_interrupts_instruction)
    |=> !o_global_int_gate)
    else $error("enable beat disable in same cycle");

  AST_EI_BEATS_WR0: assert property (
    (i_clk_en && i_core_evt.enable_interrupts_instruction && !i_core_evt.ack &&
    !i_core_evt.disable_interrupts_instruction && i_ctrl_wr.wr && !i_ctrl_wr.data[GATE_BIT]) |=> o_global_int_gate)
    else $error("write of zero beat enable instruction");

  AST_IDLE_HOLDS: assert property (
    (i_clk_en && no_core && !i_ctrl_wr.wr) |=> $stable(o_global_int_gate))
    else $error("gate changed with no event");

  AST_RESET_PEND: assert property (disable iff (1'b0)
    i_srst |=> ((o_pending == '0) && (o_ctrl_value == CTRL_RESET)))
    else $error("reset left pending or control image set");

endmodule

// >>> verilog/mie_pend_latch.sv
// Latch bank that keeps interrupt requests pending until serviced
`timescale 1ns/1ps
module mie_pend_latch
  import mie_pkg::*;
#(
  parameter int N = NUM_SOURCES
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_clk_en,
  input wire logic [N-1:0] i_set,
  input wire logic i_clr_en,
  input wire logic [N-1:0] i_clr,
  output logic [N-1:0] o_pending
);

  // A request arriving in the cycle of its own clear survives
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_pending <= '0;
    end else if (i_clk_en) begin
      o_pending <= (o_pending & ~(i_clr & {N{i_clr_en}})) | i_set;
    end
  end

endmodule

// >>> verilog/mie_pkg.sv
// Package for the master interrupt enable block: constants and carrier types
package mie_pkg;

  localparam int CTRL_WIDTH = 8;
  localparam int GATE_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic GATE_RESET = 1'b0;
  localparam int NUM_SOURCES = 8;

  // Instruction and acknowledge events reported by the core, one-cycle pulses
  typedef struct packed {
    logic enable_interrupts_instruction;
    logic disable_interrupts_instruction;
    logic return_from_service_instruction;
    logic ack;
  } mie_core_evt_type;

  // Software write to the interrupt control register
  typedef struct packed {
    logic wr;
    logic [CTRL_WIDTH-1:0] data;
  } mie_ctrl_wr_type;

endpackage
